// ### boundary_scan_port.sv
// boundary-scan test port: synchronised tap controller, instructions, pad muxing
// Notes on behaviour
// - boundary scan only when mode select high
// - extest, sample and bypass instructions
// - mode low: emulation port, private id
// - mode taken only at chip reset
// - scan chain is 484 cells
// - bidirectional pads use three cells
// - output cell drives pad under extest
// - input cell captures the pad level
// - control cell sets pad direction
// - top cells and shared group controls
// - descending triples, internal cells interleaved
// - tdi enters, tdo leaves the chain
`timescale 1ns/1ps
module boundary_scan_port #(
  parameter int N = scan_port_pkg::CHAIN_LEN,
  parameter logic [scan_port_pkg::ID_W-1:0] EMU_ID = 32'h1234_5671 // arbitrary value
) (
  // system
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // test port pins
  input wire logic TCK,
  input wire logic TMS,
  input wire logic TDI,
  input wire logic DEBUG_LOGIC_RESET_N,
  input wire logic SCAN_MODE_SELECT,
  output logic TDO,
  output logic TDO_OE_N,
  output logic RTCK,
  output logic EMULATION_PORT_MODE,
  // pads and core
  input wire logic [N-1:0] PAD_IN,
  input wire logic [N-1:0] CORE_OUT,
  input wire logic [N-1:0] CORE_OE_N,
  output logic [N-1:0] PAD_OUT,
  output logic [N-1:0] PAD_OE_N
);

  logic rst_meta_r;
  logic rst_n;
  logic [scan_port_pkg::SYNC_W-1:0] meta_r;
  logic [scan_port_pkg::SYNC_W-1:0] sync_r;
  logic tck_d_r;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic sel_s;
  logic rise;
  logic fall;

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // pin synchronisers; only the second stage is read
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 5'h08;
      sync_r <= 5'h08;
      tck_d_r <= 1'b0;
    end else begin
      meta_r <= {SCAN_MODE_SELECT, DEBUG_LOGIC_RESET_N, TDI, TMS, TCK};
      sync_r <= meta_r;
      tck_d_r <= sync_r[0];
    end
  end
  assign tck_s = sync_r[0];
  assign tms_s = sync_r[1];
  assign tdi_s = sync_r[2];
  assign trst_n_s = sync_r[3];
  assign sel_s = sync_r[4];
  assign rise = tck_s & ~tck_d_r;
  assign fall = ~tck_s & tck_d_r;

  // mode is latched once after reset release and frozen until the next chip reset
  logic [1:0] load_cnt_r;
  logic [1:0] load_cnt_nxt;
  logic loaded_r;
  logic loaded_nxt;
  logic scan_mode_r;
  logic scan_mode_nxt;

  always_comb begin
    load_cnt_nxt = load_cnt_r;
    loaded_nxt = loaded_r;
    scan_mode_nxt = scan_mode_r;
    if (!loaded_r) begin
      load_cnt_nxt = load_cnt_r + 2'h1;
      if (load_cnt_r == 2'(scan_port_pkg::MODE_LOAD_CYC - 1)) begin
        loaded_nxt = 1'b1;
        scan_mode_nxt = sel_s;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      load_cnt_r <= 2'h0;
      loaded_r <= 1'b0;
      scan_mode_r <= 1'b0;
    end else begin
      load_cnt_r <= load_cnt_nxt;
      loaded_r <= loaded_nxt;
      scan_mode_r <= scan_mode_nxt;
    end
  end

  // tap controller and its registers
  scan_port_pkg::tap_state_type st_r;
  scan_port_pkg::tap_state_type st_nxt;
  logic [scan_port_pkg::IR_W-1:0] ir_sr_r;
  logic [scan_port_pkg::IR_W-1:0] ir_sr_nxt;
  logic [scan_port_pkg::IR_W-1:0] ir_r;
  logic [scan_port_pkg::IR_W-1:0] ir_nxt;
  logic byp_r;
  logic byp_nxt;
  logic [scan_port_pkg::ID_W-1:0] id_sr_r;
  logic [scan_port_pkg::ID_W-1:0] id_sr_nxt;

  always_comb begin
    st_nxt = st_r;
    if (rise) begin
      unique case (st_r)
        scan_port_pkg::TLR: st_nxt = tms_s ? scan_port_pkg::TLR : scan_port_pkg::RTI;
        scan_port_pkg::RTI: st_nxt = tms_s ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
        scan_port_pkg::SEL_DR: st_nxt = tms_s ? scan_port_pkg::SEL_IR : scan_port_pkg::CAP_DR;
        scan_port_pkg::CAP_DR: st_nxt = tms_s ? scan_port_pkg::EX1_DR : scan_port_pkg::SH_DR;
        scan_port_pkg::SH_DR: st_nxt = tms_s ? scan_port_pkg::EX1_DR : scan_port_pkg::SH_DR;
        scan_port_pkg::EX1_DR: st_nxt = tms_s ? scan_port_pkg::UPD_DR : scan_port_pkg::PAU_DR;
        scan_port_pkg::PAU_DR: st_nxt = tms_s ? scan_port_pkg::EX2_DR : scan_port_pkg::PAU_DR;
        scan_port_pkg::EX2_DR: st_nxt = tms_s ? scan_port_pkg::UPD_DR : scan_port_pkg::SH_DR;
        scan_port_pkg::UPD_DR: st_nxt = tms_s ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
        scan_port_pkg::SEL_IR: st_nxt = tms_s ? scan_port_pkg::TLR : scan_port_pkg::CAP_IR;
        scan_port_pkg::CAP_IR: st_nxt = tms_s ? scan_port_pkg::EX1_IR : scan_port_pkg::SH_IR;
        scan_port_pkg::SH_IR: st_nxt = tms_s ? scan_port_pkg::EX1_IR : scan_port_pkg::SH_IR;
        scan_port_pkg::EX1_IR: st_nxt = tms_s ? scan_port_pkg::UPD_IR : scan_port_pkg::PAU_IR;
        scan_port_pkg::PAU_IR: st_nxt = tms_s ? scan_port_pkg::EX2_IR : scan_port_pkg::PAU_IR;
        scan_port_pkg::EX2_IR: st_nxt = tms_s ? scan_port_pkg::UPD_IR : scan_port_pkg::SH_IR;
        scan_port_pkg::UPD_IR: st_nxt = tms_s ? scan_port_pkg::SEL_DR : scan_port_pkg::RTI;
      endcase
    end
    // debug reset pin or mode not yet latched holds the tap in reset
    if (!trst_n_s || !loaded_r) begin
      st_nxt = scan_port_pkg::TLR;
    end
  end

  logic bsel;
  logic extest;
  assign extest = scan_mode_r && ir_r == scan_port_pkg::IR_EXTEST;
  assign bsel = scan_mode_r && (extest || ir_r == scan_port_pkg::IR_SAMPLE);

  always_comb begin
    ir_sr_nxt = ir_sr_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    id_sr_nxt = id_sr_r;
    if (rise) begin
      unique case (st_r)
        scan_port_pkg::CAP_IR: ir_sr_nxt = scan_port_pkg::IR_CAPTURE;
        scan_port_pkg::SH_IR: ir_sr_nxt = {tdi_s, ir_sr_r[scan_port_pkg::IR_W-1:1]};
        scan_port_pkg::UPD_IR: ir_nxt = ir_sr_r;
        scan_port_pkg::CAP_DR: begin
          byp_nxt = 1'b0;
          id_sr_nxt = EMU_ID;
        end
        scan_port_pkg::SH_DR: begin
          byp_nxt = tdi_s;
          id_sr_nxt = {tdi_s, id_sr_r[scan_port_pkg::ID_W-1:1]};
        end
        default: begin
        end
      endcase
    end
    if (st_r == scan_port_pkg::TLR) begin
      ir_nxt = scan_port_pkg::IR_RESET;
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= scan_port_pkg::TLR;
      ir_sr_r <= scan_port_pkg::IR_RESET;
      ir_r <= scan_port_pkg::IR_RESET;
      byp_r <= 1'b0;
      id_sr_r <= '0;
    end else begin
      st_r <= st_nxt;
      ir_sr_r <= ir_sr_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      id_sr_r <= id_sr_nxt;
    end
  end

  // boundary chain
  logic chain_so;
  logic [N-1:0] upd_q;
  logic [N-1:0] core_val;
  logic ch_cap;
  logic ch_shift;
  logic ch_upd;

  for (genvar i = 0; i < N; i++) begin : g_core
    localparam logic [1:0] KIND = scan_port_pkg::kind_of(i);
    assign core_val[i] = (KIND == scan_port_pkg::CELL_CTL) ? ~CORE_OE_N[i] : CORE_OUT[i];
  end

  assign ch_cap = rise && bsel && st_r == scan_port_pkg::CAP_DR;
  assign ch_shift = rise && bsel && st_r == scan_port_pkg::SH_DR;
  assign ch_upd = rise && bsel && st_r == scan_port_pkg::UPD_DR;

  pad_scan_chain #(.N(N)) u_chain (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .pad_in(PAD_IN),
    .core_val(core_val),
    .capture(ch_cap),
    .shift(ch_shift),
    .update(ch_upd),
    .tdi(tdi_s),
    .so(chain_so),
    .upd_q(upd_q)
  );

  // pad drive: core path normally, update cells under extest
  logic [N-1:0] pad_out_nxt;
  logic [N-1:0] pad_oe_n_nxt;
  logic [N-1:0] pad_out_r;
  logic [N-1:0] pad_oe_n_r;

  for (genvar i = 0; i < N; i++) begin : g_pad
    localparam logic [1:0] KIND = scan_port_pkg::kind_of(i);
    localparam int CTL = scan_port_pkg::ctl_of(i);
    if (KIND == scan_port_pkg::CELL_OUT) begin : g_out
      assign pad_out_nxt[i] = extest ? upd_q[i] : CORE_OUT[i];
      assign pad_oe_n_nxt[i] = extest ? ~upd_q[CTL] : CORE_OE_N[i];
    end else begin : g_none
      assign pad_out_nxt[i] = 1'b0;
      assign pad_oe_n_nxt[i] = 1'b1;
    end
  end

  // tdo changes on the falling test clock
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_oe_n_r;
  logic tdo_oe_n_nxt;
  logic rtck_r;

  always_comb begin
    tdo_nxt = tdo_r;
    tdo_oe_n_nxt = tdo_oe_n_r;
    if (fall) begin
      tdo_oe_n_nxt = ~(st_r == scan_port_pkg::SH_IR || st_r == scan_port_pkg::SH_DR);
      if (st_r == scan_port_pkg::SH_IR) begin
        tdo_nxt = ir_sr_r[0];
      end else if (!scan_mode_r) begin
        tdo_nxt = id_sr_r[0];
      end else if (bsel) begin
        tdo_nxt = chain_so;
      end else begin
        tdo_nxt = byp_r;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      pad_out_r <= '0;
      pad_oe_n_r <= '1;
      tdo_r <= 1'b0;
      tdo_oe_n_r <= 1'b1;
      rtck_r <= 1'b0;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_n_r <= pad_oe_n_nxt;
      tdo_r <= tdo_nxt;
      tdo_oe_n_r <= tdo_oe_n_nxt;
      rtck_r <= loaded_r && !scan_mode_r && tck_s;
    end
  end

  assign PAD_OUT = pad_out_r;
  assign PAD_OE_N = pad_oe_n_r;
  assign TDO = tdo_r;
  assign TDO_OE_N = tdo_oe_n_r;
  assign RTCK = rtck_r;
  assign EMULATION_PORT_MODE = loaded_r && !scan_mode_r;

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  a_mode_frozen: assert property (loaded_r |=> loaded_r && $stable(scan_mode_r))
    else $error("scan mode changed without chip reset");
  a_trst_reset: assert property (!trst_n_s |=> st_r == scan_port_pkg::TLR)
    else $error("debug reset did not return tap to reset");
  a_tlr_ir: assert property (st_r == scan_port_pkg::TLR |=> ir_r == scan_port_pkg::IR_BYPASS)
    else $error("instruction not bypass in reset state");
  a_emul_id: assert property (rise && st_r == scan_port_pkg::CAP_DR |=> id_sr_r == EMU_ID)
    else $error("emulation id not captured");
  a_bypass_cap: assert property (rise && st_r == scan_port_pkg::CAP_DR |=> !byp_r)
    else $error("bypass cell did not capture zero");
  a_no_scan_emul: assert property (!scan_mode_r |=> $stable(upd_q) && $stable(chain_so))
    else $error("chain active outside scan mode");
  a_extest_drive: assert property (extest |=> PAD_OUT[483] == $past(upd_q[483])
                                  && PAD_OE_N[483] == !$past(upd_q[482]))
    else $error("extest did not drive address pad from its cells");
  a_data_dir: assert property (extest |=> PAD_OE_N[455] == !$past(upd_q[454]))
    else $error("data pad direction not from its control cell");
  a_core_pass: assert property (!extest |=> PAD_OUT[464] == $past(CORE_OUT[464]))
    else $error("pad not driven from core outside extest");
  a_tdo_quiet: assert property (fall && st_r == scan_port_pkg::RTI |=> TDO_OE_N)
    else $error("tdo driven outside shift");
  c_extest: cover property (extest && ch_upd);
  c_sample: cover property (bsel && !extest && ch_cap);
  c_emul_shift: cover property (!scan_mode_r && loaded_r && rise && st_r == scan_port_pkg::SH_DR);
endmodule : boundary_scan_port

// ### scan_port_pkg.sv
// constants, cell map and tap states for the boundary-scan port
package scan_port_pkg;
  localparam int CHAIN_LEN = 484;
  localparam int IR_W = 4;
  localparam int ID_W = 32;
  localparam int SYNC_W = 5;
  localparam int MODE_LOAD_CYC = 3;
  localparam logic [IR_W-1:0] IR_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] IR_SAMPLE = 4'h1;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
  localparam logic [IR_W-1:0] IR_RESET = 4'hF;
  // cell kinds
  localparam logic [1:0] CELL_INT = 2'h0;
  localparam logic [1:0] CELL_IN = 2'h1;
  localparam logic [1:0] CELL_OUT = 2'h2;
  localparam logic [1:0] CELL_CTL = 2'h3;
  // shared group controls, top cell and chain layout bounds
  localparam int CTL_ADDR_HI = 482;
  localparam int CTL_ADDR_LO = 476;
  localparam int CTL_STROBES = 474;
  localparam int CTL_SDRAM = 463;
  localparam int CELL_TOP = 483;
  localparam int TRIPLE_END = 405;
  localparam int QUAD_BASE = 404;

  typedef enum logic [3:0] {
    TLR = 4'hF, RTI = 4'hC, SEL_DR = 4'h7, CAP_DR = 4'h6,
    SH_DR = 4'h2, EX1_DR = 4'h1, PAU_DR = 4'h3, EX2_DR = 4'h0,
    UPD_DR = 4'h5, SEL_IR = 4'h4, CAP_IR = 4'hE, SH_IR = 4'hA,
    EX1_IR = 4'h9, PAU_IR = 4'hB, EX2_IR = 4'h8, UPD_IR = 4'hD
  } tap_state_type;

  function automatic logic [1:0] kind_of(input int i);
    int base;
    int m;
    case (i)
      483, 481, 480, 479, 478, 477, 475, 473, 472, 471, 469, 467, 465, 464, 461, 459, 458, 457, 455:
        return CELL_OUT;
      482, 476, 474, 463, 460, 454: return CELL_CTL;
      470, 468, 462, 456: return CELL_IN;
      466, 453, 440, 427, 414: return CELL_INT;
      default: begin
        if (i >= TRIPLE_END) begin
          base = (i >= 441) ? 452 : (i >= 428) ? 439 : (i >= 415) ? 426 : 413;
          m = (base - i) % 3;
          return (m == 0) ? CELL_IN : (m == 1) ? CELL_OUT : CELL_CTL;
        end
        m = (QUAD_BASE - i) % 4;
        return (m == 0) ? CELL_IN : (m == 1) ? CELL_OUT : (m == 2) ? CELL_CTL : CELL_INT;
      end
    endcase
  endfunction : kind_of

  function automatic int ctl_of(input int i);
    case (i)
      483, 481, 480, 479, 478: return CTL_ADDR_HI;
      477, 475, 473, 472, 471, 469, 467, 465: return CTL_STROBES;
      464, 459, 458, 457: return CTL_SDRAM;
      default: return i - 1;
    endcase
  endfunction : ctl_of
endpackage : scan_port_pkg

// ### pad_scan_chain.sv
// boundary-scan cell chain with pad synchronisers, shift and update stages
`timescale 1ns/1ps
module pad_scan_chain #(
  parameter int N = scan_port_pkg::CHAIN_LEN
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pad and core side
  input wire logic [N-1:0] pad_in,
  input wire logic [N-1:0] core_val,
  // control from the tap
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  input wire logic tdi,
  // results
  output logic so,
  output logic [N-1:0] upd_q
);
  logic [N-1:0] meta_r;
  logic [N-1:0] pad_s_r;
  logic [N-1:0] sr_r;
  logic [N-1:0] sr_nxt;
  logic [N-1:0] upd_r;
  logic [N-1:0] upd_nxt;

  for (genvar i = 0; i < N; i++) begin : g_cell
    localparam logic [1:0] KIND = scan_port_pkg::kind_of(i);
    logic cap_v;
    logic shift_v;
    // input cells see the pad, output and control cells the core, internal cells zero
    assign cap_v = (KIND == scan_port_pkg::CELL_IN) ? pad_s_r[i] :
                   (KIND == scan_port_pkg::CELL_INT) ? 1'b0 : core_val[i];
    if (i == N - 1) begin : g_head
      assign shift_v = tdi;
    end else begin : g_body
      assign shift_v = sr_r[i+1];
    end
    always_comb begin
      sr_nxt[i] = sr_r[i];
      upd_nxt[i] = upd_r[i];
      if (capture) begin
        sr_nxt[i] = cap_v;
      end else if (shift) begin
        sr_nxt[i] = shift_v;
      end
      if (update) begin
        upd_nxt[i] = sr_r[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      pad_s_r <= '0;
      sr_r <= '0;
      upd_r <= '0;
    end else begin
      meta_r <= pad_in;
      pad_s_r <= meta_r;
      sr_r <= sr_nxt;
      upd_r <= upd_nxt;
    end
  end

  assign so = sr_r[0];
  assign upd_q = upd_r;

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_shift_entry: assert property (shift && !capture |=> sr_r[N-1] == $past(tdi))
    else $error("chain head did not take the serial input");
  a_shift_walk: assert property (shift && !capture |=> sr_r[0] == $past(sr_r[1]))
    else $error("chain did not advance toward the output");
  a_input_cap: assert property (capture |=> sr_r[470] == $past(pad_s_r[470]))
    else $error("input cell did not capture the pad level");
  a_int_cap: assert property (capture |=> sr_r[466] == 1'b0)
    else $error("internal cell captured non-zero");
endmodule : pad_scan_chain

// ### scan_tester.sv
// tester model: paces the test clock and shifts serial frames
`timescale 1ns/1ps
module scan_tester (
  // pacing clock
  input wire logic clk,
  // from the device
  input wire logic tdo,
  input wire logic tdo_oe_n,
  // to the device
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic factory_test_pin
);
  logic oe_bad = 1'b0;
  logic oe_q;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    factory_test_pin = 1'b0;
  end

  // one period: 5 system cycles low, 3 high; idles low between frames
  task automatic pulse(input logic m, input logic d, output logic q);
    @(negedge clk);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk);
    q = tdo;
    oe_q = tdo_oe_n;
    tck = 1'b1;
    repeat (3) @(negedge clk);
    tck = 1'b0;
  endtask : pulse

  task automatic reset_tap();
    logic q;
    repeat (5) pulse(1'b1, ~tdi, q);
    pulse(1'b0, ~tdi, q);
  endtask : reset_tap

  // from idle: select, capture, shift lsb first, update, idle; data line toggles when unused
  task automatic scan(input logic ir, input int n, input logic [511:0] din, output logic [511:0] dout);
    logic q;
    dout = '0;
    oe_bad = 1'b0;
    pulse(1'b1, ~tdi, q);
    if (ir) pulse(1'b1, ~tdi, q);
    repeat (2) pulse(1'b0, ~tdi, q);
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
      if (oe_q !== 1'b0) oe_bad = 1'b1;
    end
    pulse(1'b1, ~tdi, q);
    pulse(1'b0, ~tdi, q);
  endtask : scan
endmodule : scan_tester

// ### testbench.sv
// self-checking bench for the boundary-scan port
`timescale 1ns/1ps
module testbench;
  localparam int N = scan_port_pkg::CHAIN_LEN;
  localparam logic [31:0] EMU_ID = 32'h0A5C_3E11; // arbitrary value
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic dbg_rst_n = 1'b1;
  logic mode_sel = 1'b1;
  logic tck, tms, tdi, tdo, tdo_oe_n, rtck, emu_mode;
  logic [N-1:0] pad_in = '0;
  logic [N-1:0] core_out = '0;
  logic [N-1:0] core_oe_n = '1;
  logic [N-1:0] pad_out, pad_oe_n;
  logic [511:0] din, dout;
  logic [3:0] codes [2] = '{scan_port_pkg::IR_BYPASS, 4'h5};
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int rtck_rises = 0;
  int rtck_base = 0;
  logic factory_test_pin;

  // returned clock edges, for the emulation and scan mode checks
  always @(posedge rtck) rtck_rises++;

  boundary_scan_port #(.N(N), .EMU_ID(EMU_ID)) boundary_scan_port_inst (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .TCK(tck), .TMS(tms), .TDI(tdi),
    .DEBUG_LOGIC_RESET_N(dbg_rst_n), .SCAN_MODE_SELECT(mode_sel), .TDO(tdo), .TDO_OE_N(tdo_oe_n),
    .RTCK(rtck), .EMULATION_PORT_MODE(emu_mode), .PAD_IN(pad_in), .CORE_OUT(core_out),
    .CORE_OE_N(core_oe_n), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n)
  );
  scan_tester scan_tester_inst (
    .clk(clk_sys), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .tck(tck), .tms(tms), .tdi(tdi),
    .factory_test_pin(factory_test_pin)
  );

  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic check(input logic [511:0] got, input logic [511:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic fill(output logic [511:0] v);
    for (int i = 0; i < 16; i++) v[i*32 +: 32] = $urandom;
  endtask : fill

  function automatic logic [511:0] mask(input int n);
    return (512'h1 << n) - 512'h1;
  endfunction : mask

  // cell kind: 0 internal, 1 input, 2 output, 3 control
  function automatic int kind(input int i);
    int j;
    j = 452 - i;
    if (i < 405) return ((404 - i) % 4 + 1) % 4;
    if (i <= 452) return (j % 13 == 12) ? 0 : j % 13 % 3 + 1;
    if (i == 453 || i == 466) return 0;
    if (i inside {482, 476, 474, 463, 460, 454}) return 3;
    if (i inside {470, 468, 462, 456}) return 1;
    return 2;
  endfunction : kind

  function automatic int ctl(input int i);
    if (i inside {483, 481, 480, 479, 478}) return 482;
    if (i inside {477, 475, 473, 472, 471, 469, 467, 465}) return 474;
    if (i inside {464, 459, 458, 457}) return 463;
    return i - 1;
  endfunction : ctl

  function automatic logic [511:0] cap_exp(input int want);
    logic [511:0] v;
    v = '0;
    for (int i = 0; i < N; i++) begin
      case (kind(i))
        1: v[i] = pad_in[i];
        2: v[i] = core_out[i];
        3: v[i] = ~core_oe_n[i];
        default: v[i] = 1'b0;
      endcase
      if (want != 0 && kind(i) != want) v[i] = 1'b0;
    end
    return v;
  endfunction : cap_exp

  task automatic check_pads(input logic ext, input logic [511:0] u);
    logic [511:0] eo, ee;
    eo = '0;
    ee = '0;
    for (int i = 0; i < N; i++) begin
      ee[i] = 1'b1;
      if (kind(i) == 2) begin
        eo[i] = ext ? u[i] : core_out[i];
        ee[i] = ext ? ~u[ctl(i)] : core_oe_n[i];
      end
    end
    check(512'(pad_out), eo);
    check(512'(pad_oe_n), ee);
  endtask : check_pads

  task automatic do_reset(input logic mode);
    @(negedge clk_sys);
    arst_n = 1'b0;
    mode_sel = mode;
    repeat (2) @(negedge clk_sys);
    check(512'(pad_oe_n), 512'({N{1'b1}}));
    check(512'(tdo_oe_n), 512'h1);
    arst_n = 1'b1;
    repeat (12) @(negedge clk_sys);
  endtask : do_reset

  task automatic ir(input logic [3:0] code, input logic chk);
    scan_tester_inst.scan(1'b1, 4, 512'(code), dout);
    if (chk) check(dout & 512'hF, 512'h1);
  endtask : ir

  task automatic chk_bypass();
    fill(din);
    scan_tester_inst.scan(1'b0, 40, din, dout);
    check(dout & mask(40), (din << 1) & mask(40));
  endtask : chk_bypass

  initial begin
    din = 512'($urandom(70121));
    do_reset(1'b1);
    check(512'(emu_mode), 512'h0);
    fill(din);
    pad_in = din[N-1:0];
    fill(din);
    core_out = din[N-1:0];
    fill(din);
    core_oe_n = din[N-1:0];
    repeat (4) @(negedge clk_sys);
    check_pads(1'b0, '0);
    scan_tester_inst.reset_tap();
    chk_bypass();
    for (int k = 0; k < 2; k++) begin
      ir(codes[k], 1'b1);
      chk_bypass();
    end
    ir(scan_port_pkg::IR_SAMPLE, 1'b1);
    fill(din);
    scan_tester_inst.scan(1'b0, N + 8, din, dout);
    check(dout & mask(N + 8), (cap_exp(0) | (din << N)) & mask(N + 8));
    check(512'(scan_tester_inst.oe_bad), 512'h0);
    check(512'({tdo_oe_n, rtck}), 512'h2);
    check_pads(1'b0, '0);
    ir(scan_port_pkg::IR_EXTEST, 1'b1);
    for (int k = 0; k < 2; k++) begin
      fill(din);
      pad_in = din[N-1:0];
      repeat (4) @(negedge clk_sys);
      fill(din);
      scan_tester_inst.scan(1'b0, N, din, dout);
      repeat (4) @(negedge clk_sys);
      check_pads(1'b1, din);
      check(dout, cap_exp(1) | (dout & ~cap_mask()));
    end
    dbg_rst_n = 1'b0;
    repeat (5) @(negedge clk_sys);
    dbg_rst_n = 1'b1;
    repeat (5) @(negedge clk_sys);
    check_pads(1'b0, '0);
    scan_tester_inst.reset_tap();
    chk_bypass();
    do_reset(1'b0);
    check(512'(emu_mode), 512'h1);
    scan_tester_inst.reset_tap();
    for (int k = 0; k < 2; k++) begin
      ir(k ? scan_port_pkg::IR_EXTEST : scan_port_pkg::IR_SAMPLE, 1'b0);
      rtck_base = rtck_rises;
      scan_tester_inst.scan(1'b0, 32, din, dout);
      check(512'(rtck_rises - rtck_base), 512'h25);
      check(dout & mask(32), 512'(EMU_ID));
      check_pads(1'b0, '0);
      mode_sel = 1'b1;
      repeat (4) @(negedge clk_sys);
      check(512'(emu_mode), 512'h1);
    end
    do_reset(1'b1);
    check(512'(emu_mode), 512'h0);
    scan_tester_inst.reset_tap();
    rtck_base = rtck_rises;
    chk_bypass();
    check(512'(rtck_rises - rtck_base), 512'h0);
    check(512'(factory_test_pin), 512'h0);
    stop_test();
  end

  // input cell positions of the chain
  function automatic logic [511:0] cap_mask();
    logic [511:0] v;
    v = '0;
    for (int i = 0; i < N; i++) v[i] = (kind(i) == 1);
    return v;
  endfunction : cap_mask
endmodule : testbench
